/* File: sas_pkg.sv */
// Shared constants and carrier types of the converter sequencer
package sas_pkg;
    // Operating modes
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_SCAN   = 2'h2;
    localparam logic [1:0] MODE_CONT   = 2'h3;
    // Hardware trigger sources and conditions
    localparam logic [1:0] TRG_SRC_EXT  = 2'h0;
    localparam logic [1:0] TRG_SRC_PWM  = 2'h3;
    localparam logic [1:0] TRG_FALL     = 2'h0;
    localparam logic [1:0] TRG_RISE     = 2'h1;
    localparam logic [1:0] TRG_LOW      = 2'h2;
    localparam logic [1:0] TRG_HIGH     = 2'h3;
    // Pin qualification, in peripheral clocks
    localparam int         LEVEL_MIN_PCLK = 8;
    localparam int         EDGE_MIN_PCLK  = 4;
    localparam logic [3:0] LEVEL_MIN      = 4'(LEVEL_MIN_PCLK);
    localparam logic [2:0] EDGE_LAST      = 3'(EDGE_MIN_PCLK - 1);
    // Result layout
    localparam int         RAW_W  = 12;
    localparam int         RES_W  = 16;
    localparam int         PAD_W  = RES_W - RAW_W;
    localparam int         CH_N   = 8;
    localparam int         CH_W   = 3;
    localparam int         FIFO_DEPTH = 8;

    typedef struct packed {
        logic [CH_W-1:0]  monitor_channel_sel;
        logic             compare_direction_bit;
        logic [RAW_W-1:0] compare_value;
        logic [3:0]       match_count_setting;
        logic             compare_irq_enable;
    } sas_cmp_cfg_t;

    typedef struct packed {
        logic             valid;
        logic             overrun;
        logic [RES_W-1:0] result_field;
    } sas_result_t;

    typedef struct packed {
        logic [CH_W-1:0]  channel;
        logic [RES_W-1:0] result_field;
    } sas_dma_word_t;
endpackage

/* File: sas_top.sv */
// Sequencer, trigger, comparator and DMA logic of the converter, with its result FIFO

// Result FIFO for DMA transfer words
module sas_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    // Honest flags from the occupancy count
    assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign out_data_o  = mem_reg[rd_ptr_reg];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Storage is not reset; only the pointers and the count carry state
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    // Pointers wrap, so depth should be a power of two
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
            if (push && !pop) count_reg <= count_reg + 1'b1;
            else if (pop && !push) count_reg <= count_reg - 1'b1;
        end
    end
endmodule

// Summary of operation
// - Converter tick: selected source over prescale+1
// - Single start converts one channel, stores
// - Single completion sets done flag, interrupt
// - Go bit reads one, self-clears at end
// - Single mode uses lowest enabled channel
// - Single scan converts enabled channels ascending
// - Scan done flag only after full pass
// - Go cleared mid-scan: finish current, store
// - Continuous scan repeats passes while go set
// - External pin trigger with four conditions
// - Level held eight clocks, start on ninth
// - Active level keeps conversions going
// - Edge states under four clocks ignored
// - PWM centre pulse starts single scan
// - Two comparators, channel, direction, value
// - Match increments counter, mismatch clears it
// - Counter at setting plus one sets flag
// - Interrupt is any enabled flag
// - Completion queues DMA request when enabled
// - One DMA data port for all channels
// - Unmoved previous result sets overrun, overwrites
// - Valid set at completion, read clears both
// - Result unsigned or sign-extended per format bit
module sas_top #(
    parameter int PRESC_W    = 8,
    parameter int FIFO_DEPTH = sas_pkg::FIFO_DEPTH
) (
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic [3:0]                  clk_src_tick_i,
    input  wire logic [1:0]                  clk_src_sel_i,
    input  wire logic [PRESC_W-1:0]          prescale_i,
    input  wire logic [1:0]                  mode_i,
    input  wire logic [sas_pkg::CH_N-1:0]    channel_enable_bits_i,
    input  wire logic                        go_set_i,
    input  wire logic                        go_clear_i,
    input  wire logic                        done_irq_enable_i,
    input  wire logic                        result_format_bit_i,
    input  wire logic                        dma_request_enable_i,
    input  wire logic                        hw_trigger_enable_i,
    input  wire logic [1:0]                  trigger_source_sel_i,
    input  wire logic [1:0]                  trigger_condition_sel_i,
    input  wire logic                        external_trigger_pin_i,
    input  wire logic                        pwm_trigger_i,
    input  wire sas_pkg::sas_cmp_cfg_t [1:0] cmp_cfg_i,
    input  wire logic                        done_flag_clear_i,
    input  wire logic [1:0]                  cmp_flag_clear_i,
    input  wire logic                        rd_en_i,
    input  wire logic [sas_pkg::CH_W-1:0]    rd_ch_i,
    output sas_pkg::sas_result_t             rd_data_o,
    output logic                             convert_go_bit_o,
    output logic                             conversion_done_flag_o,
    output logic                             compare0_flag_o,
    output logic                             compare1_flag_o,
    output logic                             irq_o,
    output logic                             conv_tick_o,
    output logic                             conv_start_o,
    output logic [sas_pkg::CH_W-1:0]         conv_channel_o,
    input  wire logic                        conv_done_i,
    input  wire logic [sas_pkg::RAW_W-1:0]   conv_data_i,
    output logic                             dma_req_o,
    input  wire logic                        dma_ack_i,
    output sas_pkg::sas_dma_word_t           dma_transfer_data_o
);
    typedef enum logic [2:0] {
        S_IDLE  = 3'b001,
        S_START = 3'b010,
        S_CONV  = 3'b100
    } sas_state_t;

    sas_state_t                        state_reg;
    logic [PRESC_W-1:0]                div_cnt_reg;
    logic                              go_reg;
    logic                              go_hw_set;
    logic                              go_set;
    logic                              fsm_clear;
    logic [sas_pkg::CH_W-1:0]          cur_ch_reg;
    logic [3:0]                        lvl_cnt_reg;
    logic [2:0]                        edge_cnt_reg;
    logic                              edge_filt_reg;
    logic                              edge_fire;
    logic                              lvl_active;
    logic                              is_level;
    logic                              hw_ok;
    logic                              done_flag_reg;
    logic [1:0]                        cmp_flag_reg;
    logic [4:0]                        match_cnt_reg [2];
    logic [1:0]                        cmp_eval;
    logic [1:0]                        cmp_hit;
    logic [1:0]                        cmp_match;
    logic [sas_pkg::RES_W-1:0]         result_reg [sas_pkg::CH_N];
    logic [sas_pkg::CH_N-1:0]          valid_reg;
    logic [sas_pkg::CH_N-1:0]          overrun_reg;
    logic [sas_pkg::CH_N-1:0]          dma_pend_reg;
    logic [sas_pkg::RES_W-1:0]         new_result;
    logic                              complete;
    logic [3:0]                        first_ch;
    logic [3:0]                        next_ch;
    logic                              pass_end;
    logic                              fifo_in_ready;
    logic                              fifo_push;
    logic                              dma_pop;
    sas_pkg::sas_dma_word_t            push_word;

    // Lowest enabled channel at or above start; bit 3 flags a hit
    function automatic logic [3:0] find_from(input logic [7:0] mask, input logic [3:0] start);
        logic [3:0] res;
        res = 4'h0;
        for (int i = sas_pkg::CH_N - 1; i >= 0; i--) begin
            if (mask[i] && (i >= int'(start))) res = {1'b1, 3'(i)};
        end
        return res;
    endfunction

    // converter clock divider
    // Source selection and divide by prescale plus one, as a tick
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_cnt_reg <= '0;
        end else if (clk_src_tick_i[clk_src_sel_i]) begin
            div_cnt_reg <= (div_cnt_reg == prescale_i) ? '0 : div_cnt_reg + 1'b1;
        end
    end
    assign conv_tick_o = clk_src_tick_i[clk_src_sel_i] && (div_cnt_reg == prescale_i);

    // trigger source and condition decode
    // Hardware starts are taken in single-cycle scan mode only
    assign hw_ok      = hw_trigger_enable_i && (mode_i == sas_pkg::MODE_SCAN);
    assign is_level   = (trigger_condition_sel_i == sas_pkg::TRG_LOW) ||
                        (trigger_condition_sel_i == sas_pkg::TRG_HIGH);
    assign lvl_active = (trigger_condition_sel_i == sas_pkg::TRG_HIGH) ?
                        external_trigger_pin_i : !external_trigger_pin_i;

    // level qualification counter
    // Saturates at eight; the ninth active clock raises the go bit
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lvl_cnt_reg <= '0;
        end else if (!is_level || !lvl_active) begin
            lvl_cnt_reg <= '0;
        end else if (lvl_cnt_reg != sas_pkg::LEVEL_MIN) begin
            lvl_cnt_reg <= lvl_cnt_reg + 1'b1;
        end
    end

    // edge glitch filter
    // A new pin state must persist four clocks before it counts
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            edge_cnt_reg  <= '0;
            edge_filt_reg <= 1'b0;
        end else if (external_trigger_pin_i == edge_filt_reg) begin
            edge_cnt_reg <= '0;
        end else if (edge_cnt_reg == sas_pkg::EDGE_LAST) begin
            edge_cnt_reg  <= '0;
            edge_filt_reg <= external_trigger_pin_i;
        end else begin
            edge_cnt_reg <= edge_cnt_reg + 1'b1;
        end
    end
    assign edge_fire = (external_trigger_pin_i != edge_filt_reg) &&
                       (edge_cnt_reg == sas_pkg::EDGE_LAST) &&
                       (external_trigger_pin_i ==
                        (trigger_condition_sel_i == sas_pkg::TRG_RISE));

    // PWM centre pulse or external pin start
    // Level mode re-arms go every cycle, so passes chain while active
    always_comb begin
        go_hw_set = 1'b0;
        if (hw_ok && trigger_source_sel_i == sas_pkg::TRG_SRC_PWM) begin
            go_hw_set = pwm_trigger_i;
        end else if (hw_ok && trigger_source_sel_i == sas_pkg::TRG_SRC_EXT) begin
            go_hw_set = is_level ? (lvl_active && lvl_cnt_reg == sas_pkg::LEVEL_MIN)
                                 : edge_fire;
        end
    end

    assign go_set = go_set_i || go_hw_set;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            go_reg <= 1'b0;
        end else if (go_set) begin
            go_reg <= 1'b1;
        end else if (go_clear_i || fsm_clear) begin
            go_reg <= 1'b0;
        end
    end
    assign convert_go_bit_o = go_reg;

    // Channel walk helpers
    assign first_ch  = find_from(channel_enable_bits_i, 4'h0);
    assign next_ch   = find_from(channel_enable_bits_i, {1'b0, cur_ch_reg} + 4'h1);
    assign complete  = (state_reg == S_CONV) && conv_done_i;
    assign pass_end  = (mode_i == sas_pkg::MODE_SINGLE) || !next_ch[3];
    // go self-clears at end
    // Continuous mode keeps go; single and scan drop it at the end
    assign fsm_clear = (complete && pass_end && mode_i != sas_pkg::MODE_CONT) ||
                       ((state_reg == S_IDLE) && !first_ch[3]);

    // sequencing
    // Start waits for room in the FIFO so no result is dropped
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg  <= S_IDLE;
            cur_ch_reg <= '0;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if ((go_reg || go_set) && first_ch[3]) begin
                        cur_ch_reg <= first_ch[2:0];
                        state_reg  <= S_START;
                    end
                end
                S_START: begin
                    if (!go_reg) begin
                        state_reg <= S_IDLE;
                    end else if (conv_tick_o && (fifo_in_ready || !dma_request_enable_i)) begin
                        state_reg <= S_CONV;
                    end
                end
                S_CONV: begin
                    if (conv_done_i) begin
                        if (!go_reg || (pass_end && mode_i != sas_pkg::MODE_CONT)) begin
                            state_reg <= S_IDLE;
                        end else if (pass_end) begin
                            cur_ch_reg <= first_ch[2:0];
                            state_reg  <= first_ch[3] ? S_START : S_IDLE;
                        end else begin
                            cur_ch_reg <= next_ch[2:0];
                            state_reg  <= S_START;
                        end
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
    assign conv_start_o   = (state_reg == S_START) && go_reg && conv_tick_o &&
                            (fifo_in_ready || !dma_request_enable_i);
    assign conv_channel_o = cur_ch_reg;

    assign new_result = result_format_bit_i ?
        {{sas_pkg::PAD_W{conv_data_i[sas_pkg::RAW_W-1]}}, conv_data_i} :
        {{sas_pkg::PAD_W{1'b0}}, conv_data_i};

    // per-channel results and flags
    // A completion on the channel being read wins over the read clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            valid_reg    <= '0;
            overrun_reg  <= '0;
            dma_pend_reg <= '0;
            for (int i = 0; i < sas_pkg::CH_N; i++) result_reg[i] <= '0;
        end else begin
            if (rd_en_i) begin
                valid_reg[rd_ch_i]   <= 1'b0;
                overrun_reg[rd_ch_i] <= 1'b0;
            end
            if (dma_pop) dma_pend_reg[dma_transfer_data_o.channel] <= 1'b0;
            if (complete) begin
                result_reg[cur_ch_reg] <= new_result;
                valid_reg[cur_ch_reg]  <= 1'b1;
                if (valid_reg[cur_ch_reg] || dma_pend_reg[cur_ch_reg]) begin
                    overrun_reg[cur_ch_reg] <= 1'b1;
                end
                if (dma_request_enable_i) dma_pend_reg[cur_ch_reg] <= 1'b1;
            end
        end
    end

    // Read port of the data registers, registered
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_o <= '0;
        end else if (rd_en_i) begin
            rd_data_o <= '{valid_reg[rd_ch_i], overrun_reg[rd_ch_i], result_reg[rd_ch_i]};
        end
    end

    assign fifo_push = complete && dma_request_enable_i;
    assign push_word = '{cur_ch_reg, new_result};
    assign dma_pop   = dma_req_o && dma_ack_i;
    sas_fifo #(
        .WIDTH ($bits(sas_pkg::sas_dma_word_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (fifo_push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (push_word),
        .out_valid_o (dma_req_o),
        .out_ready_i (dma_ack_i),
        .out_data_o  (dma_transfer_data_o)
    );

    always_comb begin
        for (int k = 0; k < 2; k++) begin
            cmp_eval[k]  = complete && (cur_ch_reg == cmp_cfg_i[k].monitor_channel_sel);
            cmp_match[k] = cmp_cfg_i[k].compare_direction_bit ?
                (conv_data_i >= cmp_cfg_i[k].compare_value) :
                (conv_data_i <  cmp_cfg_i[k].compare_value);
            cmp_hit[k]   = cmp_eval[k] && cmp_match[k] &&
                (match_cnt_reg[k] + 5'h1 == {1'b0, cmp_cfg_i[k].match_count_setting} + 5'h1);
        end
    end

    // Match counters saturate once the flag threshold is reached
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            match_cnt_reg[0] <= '0;
            match_cnt_reg[1] <= '0;
        end else begin
            for (int k = 0; k < 2; k++) begin
                if (cmp_eval[k] && !cmp_match[k]) begin
                    match_cnt_reg[k] <= '0;
                end else if (cmp_eval[k] && !cmp_hit[k]) begin
                    match_cnt_reg[k] <= match_cnt_reg[k] + 5'h1;
                end
            end
        end
    end

    // sticky flags, set wins over clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            done_flag_reg <= 1'b0;
            cmp_flag_reg  <= '0;
        end else begin
            done_flag_reg <= (complete && pass_end) || (done_flag_reg && !done_flag_clear_i);
            cmp_flag_reg  <= cmp_hit | (cmp_flag_reg & ~cmp_flag_clear_i);
        end
    end
    assign conversion_done_flag_o = done_flag_reg;
    assign compare0_flag_o        = cmp_flag_reg[0];
    assign compare1_flag_o        = cmp_flag_reg[1];

    assign irq_o = (done_flag_reg && done_irq_enable_i) ||
                   (cmp_flag_reg[0] && cmp_cfg_i[0].compare_irq_enable) ||
                   (cmp_flag_reg[1] && cmp_cfg_i[1].compare_irq_enable);

    chk_done_single: assert property (@(posedge clk_i) disable iff (rst_i)
        complete && mode_i == sas_pkg::MODE_SINGLE |=> done_flag_reg)
        else $error("done flag missing after single conversion");
    chk_scan_no_early: assert property (@(posedge clk_i) disable iff (rst_i)
        complete && mode_i != sas_pkg::MODE_SINGLE && next_ch[3] && !done_flag_reg
        |=> !done_flag_reg)
        else $error("done flag set before pass end");
    chk_go_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        complete && mode_i == sas_pkg::MODE_SINGLE && !go_set |=> !go_reg)
        else $error("go bit not cleared after single conversion");
    chk_lowest_ch: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg == S_IDLE && go_reg && first_ch[3] |=> cur_ch_reg == $past(first_ch[2:0]))
        else $error("start not on lowest enabled channel");
    chk_level_ninth: assert property (@(posedge clk_i) disable iff (rst_i)
        hw_ok && trigger_source_sel_i == sas_pkg::TRG_SRC_EXT && is_level && lvl_active &&
        lvl_cnt_reg == sas_pkg::LEVEL_MIN |=> go_reg)
        else $error("level trigger did not set go");
    chk_edge_stable: assert property (@(posedge clk_i) disable iff (rst_i)
        edge_fire |-> external_trigger_pin_i == $past(external_trigger_pin_i, 3))
        else $error("edge accepted from short pulse");
    chk_valid_set: assert property (@(posedge clk_i) disable iff (rst_i)
        complete |=> valid_reg[$past(cur_ch_reg)])
        else $error("valid not set on completion");
    chk_overrun_set: assert property (@(posedge clk_i) disable iff (rst_i)
        complete && valid_reg[cur_ch_reg] |=> overrun_reg[$past(cur_ch_reg)])
        else $error("overrun not flagged");
    chk_cmp_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        cmp_eval[0] && !cmp_match[0] |=> match_cnt_reg[0] == 5'h0)
        else $error("match counter not cleared");
    chk_dma_req: assert property (@(posedge clk_i) disable iff (rst_i)
        fifo_push |=> dma_req_o)
        else $error("no DMA request after result");
    chk_irq_done: assert property (@(posedge clk_i) disable iff (rst_i)
        done_flag_reg && done_irq_enable_i |-> irq_o)
        else $error("interrupt missing for done flag");
endmodule

/* File: sas_adc_model.sv */
// Behavioural converter that answers each start after a channel-dependent delay
module sas_adc_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        start_i,
    input  wire logic [2:0]  ch_i,
    input  wire logic [11:0] base_i,
    output logic             done_o,
    output logic [11:0]      data_o
);
    logic [2:0] cnt_reg, ch_reg;
    // Delay of one to four cycles, so both prompt and slow answers occur
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= 3'h0;
        end else if (start_i) begin
            cnt_reg <= 3'h1 + 3'(ch_i[1:0]);
            ch_reg  <= ch_i;
        end else if (cnt_reg != 3'h0) begin
            cnt_reg <= cnt_reg - 3'h1;
        end
    end
    assign done_o = cnt_reg == 3'h1;
    // Data is inverted outside the done cycle so a late sample cannot match
    assign data_o = done_o ? base_i + 12'(ch_reg) : ~(base_i + 12'(ch_reg));
endmodule

/* File: sas_top_bench.sv */
// Self-checking bench for the converter sequencer
module sas_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic                        clk_i = 0, rst_i = 1, go_s = 0, ack = 0, rd_en = 0, dfc = 0;
    logic                        pwm = 0, fmt = 0, dma_en = 0, trg_en = 0, irq, go, done, cf0;
    logic                        dreq, cst, cdone, cf1, pin = 0, gclr = 0;
    logic [1:0]                  mode = 0, sel = 0, tsrc = 0, tcond = 0;
    logic [2:0]                  rd_ch = 0, cch;
    logic [3:0]                  tick = 0;
    logic [7:0]                  channel_enable_bits = 1, psc = 0;
    logic [11:0]                 base = 0, cdat;
    logic [2:0]                  chs [4] = '{3'h0, 3'h2, 3'h3, 3'h7};
    sas_pkg::sas_cmp_cfg_t [1:0] cmp = '0;
    sas_pkg::sas_result_t        rdat;
    sas_pkg::sas_dma_word_t      dw;
    int                          err_total = 0, n_checks = 0, lo;
    sas_top sas_top_inst (.clk_i, .rst_i, .clk_src_tick_i(tick), .clk_src_sel_i(sel),
        .prescale_i(psc), .mode_i(mode), .channel_enable_bits_i(channel_enable_bits), .go_set_i(go_s),
        .go_clear_i(gclr), .done_irq_enable_i(1'b1), .result_format_bit_i(fmt),
        .dma_request_enable_i(dma_en), .hw_trigger_enable_i(trg_en),
        .trigger_source_sel_i(tsrc), .trigger_condition_sel_i(tcond),
        .external_trigger_pin_i(pin), .pwm_trigger_i(pwm), .cmp_cfg_i(cmp),
        .done_flag_clear_i(dfc), .cmp_flag_clear_i(2'h0), .rd_en_i(rd_en), .rd_ch_i(rd_ch),
        .rd_data_o(rdat), .convert_go_bit_o(go), .conversion_done_flag_o(done),
        .compare0_flag_o(cf0), .compare1_flag_o(cf1), .irq_o(irq), .conv_tick_o(),
        .conv_start_o(cst), .conv_channel_o(cch), .conv_done_i(cdone), .conv_data_i(cdat),
        .dma_req_o(dreq), .dma_ack_i(ack), .dma_transfer_data_o(dw));
    sas_adc_model sas_adc_model_inst (.clk_i, .rst_i, .start_i(cst), .ch_i(cch),
        .base_i(base), .done_o(cdone), .data_o(cdat));
    // 25 MHz clock; converter sources tick at random
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) tick <= #1 4'($urandom);
    function automatic logic [15:0] fmtd(input logic [11:0] raw, input logic f);
        return f ? {{4{raw[11]}}, raw} : {4'h0, raw};
    endfunction
    // Comparator 1 has a match setting of zero, so one matching raw result flags it
    function automatic logic cmp1_exp();
        logic [2:0] c;
        c = cmp[1].monitor_channel_sel;
        return channel_enable_bits[c] &&
               (cmp[1].compare_direction_bit == (base + 12'(c) >= cmp[1].compare_value));
    endfunction
    task automatic chk(input logic [18:0] got, input logic [18:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        @(posedge clk_i);
        #1 s = 0;
    endtask
    // Bounded wait for the go bit to drop, or for the done flag when w is set
    task automatic wait_idle(input bit w = 1'b0);
        int i;
        for (i = 0; i < 800 && (w ? done !== 1'b1 : go !== 1'b0); i++) @(posedge clk_i) #1;
        if (i == 800) begin
            err_total++;
            give_verdict();
        end
    endtask
    task automatic rd(input logic [2:0] ch, input logic [17:0] exp);
        rd_ch = ch;
        pulse(rd_en);
        @(posedge clk_i) #1;
        chk({1'b0, rdat}, {1'b0, exp});
    endtask
    initial begin
        void'($urandom(96073));
        repeat (10) @(posedge clk_i);
        #1 rst_i = 0;
        // single start on random channel sets
        repeat (6) begin
            channel_enable_bits = 8'($urandom) | 8'h80;
            {fmt, sel, base, psc} =
                {1'($urandom), 2'($urandom), 12'($urandom), 8'h3 & 8'($urandom)};
            for (int i = 7; i >= 0; i--) if (channel_enable_bits[i]) lo = i;
            pulse(go_s);
            chk(19'(go), 19'h1);
            wait_idle();
            chk(19'({done, irq}), 19'h3);
            rd(3'(lo), {2'h2, fmtd(base + 12'(lo), fmt)});
            pulse(dfc);
            chk(19'(irq), 19'h0);
        end
        $display("test single done");
        // configuration changed only with the go bit low
        {mode, channel_enable_bits, fmt, dma_en, trg_en, tsrc} = {sas_pkg::MODE_SCAN, 8'h8d, 3'h7, 2'h3};
        cmp[0] = '{3'h3, 1'b1, 12'h0, 4'h1, 1'b1};
        cmp[1] = '{3'($urandom), 1'($urandom), 12'($urandom), 4'h0, 1'b0};
        base = 12'($urandom);
        for (int p = 0; p < 2; p++) begin
            pulse(pwm);
            wait_idle();
            chk(19'({done, cf0, cf1}), {16'h0, 1'b1, 1'(p), cmp1_exp()});
            for (int k = 0; k < 4 && p == 0; k++) begin
                chk(dw, {chs[k], fmtd(base + 12'(chs[k]), 1'b1)});
                ack = 1;
                @(posedge clk_i) #1;
            end
            ack = 0;
        end
        chk(19'(dreq), 19'h1);
        rd(3'h2, {2'h3, fmtd(base + 12'h2, 1'b1)});
        rd(3'h2, {2'h0, fmtd(base + 12'h2, 1'b1)});
        $display("test scan done");
        // continuous passes restart while the go bit stays set
        {mode, dma_en, trg_en} = {sas_pkg::MODE_CONT, 2'h0};
        pulse(go_s);
        for (int p = 0; p < 2; p++) begin
            pulse(dfc);
            wait_idle(1'b1);
            chk(19'(go), 19'h1);
        end
        pulse(gclr);
        chk(19'(go), 19'h0);
        $display("test continuous done");
        // high level: go rises on the ninth clock and is re-armed while it lasts
        {mode, trg_en, tsrc, tcond, pin} =
            {sas_pkg::MODE_SCAN, 1'b1, sas_pkg::TRG_SRC_EXT, sas_pkg::TRG_HIGH, 1'b1};
        repeat (8) @(posedge clk_i) #1;
        chk(19'(go), 19'h0);
        @(posedge clk_i) #1;
        chk(19'(go), 19'h1);
        pulse(dfc);
        wait_idle(1'b1);
        chk(19'(go), 19'h1);
        pin = 1'b0;
        wait_idle();
        // rising edge: a three-clock pulse is ignored, a four-clock one starts
        tcond = sas_pkg::TRG_RISE;
        pin = 1'b1;
        repeat (3) @(posedge clk_i) #1;
        pin = 1'b0;
        repeat (4) @(posedge clk_i) #1;
        chk(19'(go), 19'h0);
        pin = 1'b1;
        repeat (4) @(posedge clk_i) #1;
        chk(19'(go), 19'h1);
        wait_idle();
        $display("test trigger done");
        give_verdict();
    end
endmodule
